// ==== rtl/tpt_pkg.sv ====
// Constants and state types for the touch panel two-wire target port
// Behaviour
// - The port only ever answers as a bus target and never drives the serial clock.
// - The upper three bits of the seven-bit target address are fixed at binary 011.
// - The lower four address bits come from bits 7 to 4 of the address configuration value.
// - A direction bit of zero after the address makes the transfer a host write into the port.
// - A direction bit of one after the address makes the port drive data bytes to the host.
// - A stop condition ends whatever transfer is in progress.
// - A repeated start ends the current packet and opens a new one at the address phase.
// - A dedicated interrupt line, separate from the bus, tells the host of touch activity.
`default_nettype none
package tpt_pkg;

    // ========================================================================
    // Address layout
    localparam logic [2:0] TPT_ADDR_FIXED   = 3'h3;
    localparam int         TPT_ADDR_FIX_HI  = 6;
    localparam int         TPT_ADDR_FIX_LO  = 4;
    localparam int         TPT_ADDR_CFG_HI  = 3;
    localparam int         TPT_CFG_FIELD_HI = 7;
    localparam int         TPT_CFG_FIELD_LO = 4;

    // ========================================================================
    // Direction bit and bit counting
    localparam logic       TPT_DIR_WRITE    = 1'h0;
    localparam logic       TPT_DIR_READ     = 1'h1;
    localparam logic [2:0] TPT_LAST_BIT     = 3'h7;
    localparam logic [2:0] TPT_FIRST_BIT    = 3'h0;
    localparam logic [7:0] TPT_CFG_RESET    = 8'h00;
    localparam logic [7:0] TPT_BYTE_ZERO    = 8'h00;

    // ========================================================================
    // Link state machine
    typedef enum logic [2:0] {
        TPT_IDLE,
        TPT_ADDR,
        TPT_ADDR_ACK,
        TPT_WR_BYTE,
        TPT_WR_ACK,
        TPT_RD_BYTE,
        TPT_RD_ACK
    } tpt_state_t;

endpackage
`default_nettype wire

// ==== rtl/tpt_sync.sv ====
// Two flip-flop synchroniser, one stage pair per bit
`timescale 1ns/10ps
`default_nettype none
module tpt_sync
    import tpt_pkg::*;
#(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input  wire logic             clk_i,
    input  wire logic             nrst_i,
    // Data
    input  wire logic [WIDTH-1:0] d_i,
    output var  logic [WIDTH-1:0] q_o
);

    logic [WIDTH-1:0] meta_reg;

    // ========================================================================
    // Stages
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            meta_reg <= '0;
            q_o      <= '0;
        end else begin
            meta_reg <= d_i;
            q_o      <= meta_reg;
        end
    end

endmodule
`default_nettype wire

// ==== rtl/tpt_target.sv ====
// Touch panel two-wire bus target port with interrupt line
`timescale 1ns/10ps
`default_nettype none
module tpt_target
    import tpt_pkg::*;
(
    // System clock and reset
    input  wire logic       clk_i,
    input  wire logic       nrst_i,
    // Link clock
    input  wire logic       link_clk_i,
    // Bus pins
    input  wire logic       scl_i,
    input  wire logic       sda_i,
    output logic            sda_out_o,
    output logic            sda_oe_o,
    // Core side
    input  wire logic [7:0] bus_address_config_reg_i,
    input  wire logic [7:0] tx_data_i,
    output logic            tx_take_o,
    output logic [7:0]      rx_data_o,
    output logic            rx_valid_o,
    // Touch interrupt
    input  wire logic       touch_evt_i,
    input  wire logic       touch_ack_i,
    output logic            touch_int_n_o
);

    // ========================================================================
    // System domain signals
    logic [7:0] cfg_reg;
    logic [7:0] tx_hold_reg;
    logic       rx_tgl_s;
    logic       rx_tgl_q_reg;
    logic       rd_tgl_s;
    logic       rd_tgl_q_reg;

    // ========================================================================
    // Link domain signals
    logic       link_nrst;
    logic       scl_s;
    logic       sda_s;
    logic       scl_q_reg;
    logic       sda_q_reg;
    logic [3:0] addr_lo_s;
    tpt_state_t state_reg;
    logic [2:0] bit_cnt_reg;
    logic [7:0] shift_reg;
    logic       byte_done_reg;
    logic       dir_reg;
    logic [7:0] rx_byte_reg;
    logic       rx_tgl_reg;
    logic       rd_tgl_reg;
    logic       scl_rise;
    logic       scl_fall;
    logic       start_det;
    logic       stop_det;
    logic       addr_match;

    // ========================================================================
    // Reset into link domain
    tpt_sync #(.WIDTH(1)) u_rst_sync (
        .clk_i  (link_clk_i),
        .nrst_i (1'h1),
        .d_i    (nrst_i),
        .q_o    (link_nrst)
    );

    // ========================================================================
    // Pin and configuration synchronisers
    tpt_sync #(.WIDTH(6)) u_pin_sync (
        .clk_i  (link_clk_i),
        .nrst_i (1'h1),
        .d_i    ({scl_i, sda_i, cfg_reg[TPT_CFG_FIELD_HI:TPT_CFG_FIELD_LO]}),
        .q_o    ({scl_s, sda_s, addr_lo_s})
    );

    // ========================================================================
    // Handshake toggles into system domain
    tpt_sync #(.WIDTH(2)) u_tgl_sync (
        .clk_i  (clk_i),
        .nrst_i (nrst_i),
        .d_i    ({rx_tgl_reg, rd_tgl_reg}),
        .q_o    ({rx_tgl_s, rd_tgl_s})
    );

    // ========================================================================
    // Link bus event detection
    assign scl_rise   = scl_s & ~scl_q_reg;
    assign scl_fall   = ~scl_s & scl_q_reg;
    assign start_det  = scl_s & scl_q_reg & sda_q_reg & ~sda_s;
    assign stop_det   = scl_s & scl_q_reg & ~sda_q_reg & sda_s;
    assign addr_match = (shift_reg[7:5] == TPT_ADDR_FIXED) &&
                        (shift_reg[4:1] == addr_lo_s);

    always_ff @(posedge link_clk_i) begin
        if (!link_nrst) begin
            scl_q_reg <= 1'h1;
            sda_q_reg <= 1'h1;
        end else begin
            scl_q_reg <= scl_s;
            sda_q_reg <= sda_s;
        end
    end

    // ========================================================================
    // Link state machine, shifter and data driver
    always_ff @(posedge link_clk_i) begin
        if (!link_nrst) begin
            state_reg     <= TPT_IDLE;
            bit_cnt_reg   <= TPT_FIRST_BIT;
            shift_reg     <= TPT_BYTE_ZERO;
            byte_done_reg <= 1'h0;
            dir_reg       <= TPT_DIR_WRITE;
            sda_out_o     <= 1'h0;
            sda_oe_o      <= 1'h0;
            rx_byte_reg   <= TPT_BYTE_ZERO;
            rx_tgl_reg    <= 1'h0;
            rd_tgl_reg    <= 1'h0;
        end else if (stop_det) begin
            state_reg     <= TPT_IDLE;
            sda_oe_o      <= 1'h0;
            byte_done_reg <= 1'h0;
        end else if (start_det) begin
            state_reg     <= TPT_ADDR;
            bit_cnt_reg   <= TPT_FIRST_BIT;
            sda_oe_o      <= 1'h0;
            byte_done_reg <= 1'h0;
        end else begin
            sda_out_o <= 1'h0;
            case (state_reg)
                TPT_ADDR, TPT_WR_BYTE: begin
                    if (scl_rise) begin
                        shift_reg   <= {shift_reg[6:0], sda_s};
                        bit_cnt_reg <= bit_cnt_reg + 3'h1;
                        if (bit_cnt_reg == TPT_LAST_BIT) begin
                            byte_done_reg <= 1'h1;
                        end
                    end else if (scl_fall && byte_done_reg) begin
                        byte_done_reg <= 1'h0;
                        if (state_reg == TPT_WR_BYTE) begin
                            rx_byte_reg <= shift_reg;
                            rx_tgl_reg  <= ~rx_tgl_reg;
                            sda_oe_o    <= 1'h1;
                            state_reg   <= TPT_WR_ACK;
                        end else if (addr_match) begin
                            dir_reg   <= shift_reg[0];
                            sda_oe_o  <= 1'h1;
                            state_reg <= TPT_ADDR_ACK;
                            if (shift_reg[0] == TPT_DIR_READ) begin
                                rd_tgl_reg <= ~rd_tgl_reg;
                            end
                        end else begin
                            state_reg <= TPT_IDLE;
                        end
                    end
                end
                TPT_ADDR_ACK, TPT_WR_ACK: begin
                    if (scl_fall) begin
                        bit_cnt_reg <= TPT_FIRST_BIT;
                        if (state_reg == TPT_ADDR_ACK && dir_reg == TPT_DIR_READ) begin
                            shift_reg <= {tx_hold_reg[6:0], 1'h0};
                            sda_oe_o  <= ~tx_hold_reg[7];
                            state_reg <= TPT_RD_BYTE;
                        end else begin
                            sda_oe_o  <= 1'h0;
                            state_reg <= TPT_WR_BYTE;
                        end
                    end
                end
                TPT_RD_BYTE: begin
                    if (scl_fall) begin
                        bit_cnt_reg <= bit_cnt_reg + 3'h1;
                        if (bit_cnt_reg == TPT_LAST_BIT) begin
                            sda_oe_o  <= 1'h0;
                            state_reg <= TPT_RD_ACK;
                        end else begin
                            sda_oe_o  <= ~shift_reg[7];
                            shift_reg <= {shift_reg[6:0], 1'h0};
                        end
                    end
                end
                TPT_RD_ACK: begin
                    if (scl_rise) begin
                        if (sda_s) begin
                            state_reg <= TPT_IDLE;
                        end else begin
                            rd_tgl_reg <= ~rd_tgl_reg;
                        end
                    end else if (scl_fall) begin
                        bit_cnt_reg <= TPT_FIRST_BIT;
                        shift_reg   <= {tx_hold_reg[6:0], 1'h0};
                        sda_oe_o    <= ~tx_hold_reg[7];
                        state_reg   <= TPT_RD_BYTE;
                    end
                end
                TPT_IDLE: begin
                    sda_oe_o <= 1'h0;
                end
                default: begin
                    state_reg <= TPT_IDLE;
                    sda_oe_o  <= 1'h0;
                end
            endcase
        end
    end

    // ========================================================================
    // System side configuration capture
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            cfg_reg <= TPT_CFG_RESET;
        end else begin
            cfg_reg <= bus_address_config_reg_i;
        end
    end

    // ========================================================================
    // System side receive hand-off
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            rx_tgl_q_reg <= 1'h0;
            rx_data_o    <= TPT_BYTE_ZERO;
            rx_valid_o   <= 1'h0;
        end else begin
            rx_tgl_q_reg <= rx_tgl_s;
            rx_valid_o   <= rx_tgl_s ^ rx_tgl_q_reg;
            if (rx_tgl_s ^ rx_tgl_q_reg) begin
                rx_data_o <= rx_byte_reg;
            end
        end
    end

    // ========================================================================
    // System side transmit prefetch
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            rd_tgl_q_reg <= 1'h0;
            tx_hold_reg  <= TPT_BYTE_ZERO;
            tx_take_o    <= 1'h0;
        end else begin
            rd_tgl_q_reg <= rd_tgl_s;
            tx_take_o    <= rd_tgl_s ^ rd_tgl_q_reg;
            if (rd_tgl_s ^ rd_tgl_q_reg) begin
                tx_hold_reg <= tx_data_i;
            end
        end
    end

    // ========================================================================
    // Touch interrupt line
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            touch_int_n_o <= 1'h1;
        end else if (touch_evt_i) begin
            touch_int_n_o <= 1'h0;
        end else if (touch_ack_i) begin
            touch_int_n_o <= 1'h1;
        end
    end

endmodule
`default_nettype wire

// ==== verif/tpt_target_assertions.sv ====
// Concurrent checks on the target port
`timescale 1ns/10ps
`default_nettype none
module tpt_target_assertions (
    // Watched ports
    input wire logic       clk_i,
    input wire logic       nrst_i,
    input wire logic       link_clk_i,
    input wire logic       scl_i,
    input wire logic       sda_i,
    input wire logic       sda_out_o,
    input wire logic       sda_oe_o,
    input wire logic [7:0] bus_address_config_reg_i,
    input wire logic [7:0] tx_data_i,
    input wire logic       tx_take_o,
    input wire logic [7:0] rx_data_o,
    input wire logic       rx_valid_o,
    input wire logic       touch_evt_i,
    input wire logic       touch_ack_i,
    input wire logic       touch_int_n_o
);
    // ==========
    // Pin and core relations
    AST_LOW_DRIVE: assert property (@(posedge link_clk_i) disable iff (!nrst_i)
        !sda_out_o) else $error("sda drive value high");
    AST_OE_SCL_LOW: assert property (@(posedge link_clk_i) disable iff (!nrst_i)
        $changed(sda_oe_o) |-> !scl_i) else $error("sda drive moved with scl high");
    AST_STOP_FREE: assert property (@(posedge link_clk_i) disable iff (!nrst_i)
        scl_i && $rose(sda_i) |=> !sda_oe_o [*6]) else $error("sda driven after stop");
    AST_INT_SET: assert property (@(posedge clk_i) disable iff (!nrst_i)
        touch_evt_i |=> !touch_int_n_o) else $error("interrupt not raised");
    AST_INT_CLR: assert property (@(posedge clk_i) disable iff (!nrst_i)
        touch_ack_i && !touch_evt_i |=> touch_int_n_o) else $error("interrupt not cleared");
    AST_RST_VAL: assert property (@(posedge clk_i) disable iff (!nrst_i)
        $rose(nrst_i) |-> touch_int_n_o && !rx_valid_o && !tx_take_o && rx_data_o == 8'h00)
        else $error("outputs not reset");
    AST_RX_PULSE: assert property (@(posedge clk_i) disable iff (!nrst_i)
        rx_valid_o |=> !rx_valid_o) else $error("rx valid too long");
    AST_TX_PULSE: assert property (@(posedge clk_i) disable iff (!nrst_i)
        tx_take_o |=> !tx_take_o) else $error("tx take too long");
endmodule
bind tpt_target tpt_target_assertions tpt_target_assertions_i (
    .clk_i, .nrst_i, .link_clk_i, .scl_i, .sda_i, .sda_out_o, .sda_oe_o, .tx_take_o,
    .bus_address_config_reg_i, .tx_data_i, .rx_data_o, .rx_valid_o, .touch_evt_i,
    .touch_ack_i, .touch_int_n_o);
`default_nettype wire

// ==== verif/tpt_host.sv ====
// Bus controller model driving the serial clock and data line
`timescale 1ns/10ps
`default_nettype none
module tpt_host (
    // Bus pins
    output var logic  scl_o,
    output var logic  sda_pull_o,
    input  wire logic sda_i
);
    // ==========
    // Framing, clock idles high outside frames, under 400 kHz
    localparam int HALF = 1250;
    initial {scl_o, sda_pull_o} = 2'b10;
    task automatic bit_x(input logic b, output logic r);
        sda_pull_o = !b;
        #HALF scl_o = 1'b1;
        #HALF r = sda_i;
        scl_o = 1'b0;
        #40;
    endtask
    task automatic xfer(input logic [7:0] d, output logic [7:0] q);
        for (int i = 7; i >= 0; i--) bit_x(d[i], q[i]);
    endtask
    task automatic start();
        sda_pull_o = 1'b0;
        #HALF scl_o = 1'b1;
        #(4 * HALF) sda_pull_o = 1'b1;
        #(4 * HALF) scl_o = 1'b0;
        #40;
    endtask
    task automatic stop();
        sda_pull_o = 1'b1;
        #HALF scl_o = 1'b1;
        #(4 * HALF) sda_pull_o = 1'b0;
        #(4 * HALF);
    endtask
endmodule
`default_nettype wire

// ==== verif/tpt_target_bench.sv ====
// Self-checking bench for the touch panel target port
`timescale 1ns/10ps
`default_nettype none
module tpt_target_bench;
    import tpt_pkg::*;
    // ==========
    // Signals, clocks and instances
    logic        clk_i = 1'b0, link_clk_i = 1'b0, nrst_i = 1'b0, pull, r;
    logic        touch_evt_i = 1'b0, touch_ack_i = 1'b0, sda_out_o, sda_oe_o, tx_take_o;
    logic        rx_valid_o, touch_int_n_o;
    logic [7:0]  bus_address_config_reg_i = 8'h00, tx_data_i = 8'h00, rx_data_o, q, d;
    logic [6:0]  own;
    logic [31:0] seed = 32'h0000692e;
    wire logic   scl_i, sda_i;
    int          mismatches = 0, check_count = 0, cycles = 0;
    int          rx_pulses = 0, take_pulses = 0;
    always #2.5 clk_i = ~clk_i;
    initial #3.3 forever #7.5 link_clk_i = ~link_clk_i;
    assign sda_i = !(pull | sda_oe_o);
    tpt_host host (.scl_o(scl_i), .sda_pull_o(pull), .sda_i);
    tpt_target tpt_target_i (.clk_i, .nrst_i, .link_clk_i, .scl_i, .sda_i, .sda_out_o,
        .sda_oe_o, .bus_address_config_reg_i, .tx_data_i, .tx_take_o, .rx_data_o,
        .rx_valid_o, .touch_evt_i, .touch_ack_i, .touch_int_n_o);
    always @(posedge clk_i) begin
        cycles = cycles + 1;
        if (rx_valid_o === 1'b1) rx_pulses = rx_pulses + 1;
        if (tx_take_o === 1'b1) take_pulses = take_pulses + 1;
        if (cycles == 90000) mismatches = mismatches + 1;
        if (cycles == 90000) complete_run();
    end
    function automatic logic [7:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed[7:0];
    endfunction
    function automatic logic [6:0] exp_addr(input logic [7:0] cfg);
        return {TPT_ADDR_FIXED, cfg[TPT_CFG_FIELD_HI:TPT_CFG_FIELD_LO]};
    endfunction
    task automatic check(input string n, input logic [7:0] e, input logic [7:0] s);
        check_count = check_count + 1;
        if (s !== e) $display("mismatch %s expected %h seen %h", n, e, s);
        if (s !== e) mismatches = mismatches + 1;
    endtask
    task automatic complete_run();
        if (mismatches == 0 && check_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic byte_ack(input logic [7:0] b, input logic e);
        host.xfer(b, q);
        host.bit_x(1'b1, r);
        check("ack", {7'h00, e}, {7'h00, r});
    endtask
    task automatic irq(input logic [1:0] ea, input logic e);
        @(posedge clk_i) #1 {touch_evt_i, touch_ack_i} = ea;
        @(posedge clk_i) #1 {touch_evt_i, touch_ack_i} = 2'b00;
        check("interrupt", {7'h00, e}, {7'h00, touch_int_n_o});
    endtask
    initial begin
        repeat (8) @(posedge link_clk_i);
        @(posedge clk_i) #1 nrst_i = 1'b1;
        check("drive reset", 8'h00, {7'h00, sda_oe_o});
        for (int j = 0; j < 4; j++) irq(j[0] ? 2'b01 : {1'b1, j[1]}, j[0]);
        for (int k = 0; k < 2; k++) begin
            bus_address_config_reg_i = rnd();
            own = exp_addr(bus_address_config_reg_i);
            d = rnd();
            tx_data_i = rnd();
            host.start();
            byte_ack({own, TPT_DIR_WRITE}, 1'b0);
            byte_ack(d, 1'b0);
            check("written", d, rx_data_o);
            host.start();
            byte_ack({own, TPT_DIR_READ}, 1'b0);
            d = tx_data_i;
            tx_data_i = rnd();
            host.xfer(8'hff, q);
            check("read", d, q);
            host.bit_x(1'b0, r);
            host.xfer(8'hff, q);
            check("read next", tx_data_i, q);
            host.bit_x(1'b1, r);
            host.start();
            byte_ack({own ^ (k == 0 ? 7'h40 : 7'h08), TPT_DIR_WRITE}, 1'b1);
            host.start();
            for (int j = 6; j > 3; j--) host.bit_x(own[j], r);
            host.stop();
            check("drive after stop", 8'h00, {7'h00, sda_oe_o});
            check("drive value", 8'h00, {7'h00, sda_out_o});
            check("rx pulses", 8'(k + 1), rx_pulses[7:0]);
            check("take pulses", 8'(2 * k + 2), take_pulses[7:0]);
        end
        complete_run();
    end
endmodule
`default_nettype wire
